// ---- tb/tbi_core_asserts.sv ----
// port assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tbi_core_asserts (
	input wire logic               clk_sys,
	input wire logic               reset,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire tbi_pkg::tbi_core_s core_in,
	input wire tbi_pkg::tbi_vreq_s vec_out,
	input wire logic               global_irq_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence take_s; core_in.ack && vec_out.req; endsequence
	sequence setup_s; psel && !penable; endsequence
	serve_ge_a: assert property (take_s |-> ##2 !global_irq_enable)
		else $error("enable kept after service");
	serve_drop_a: assert property (take_s |-> ##2 !vec_out.req)
		else $error("vector kept after service");
	return_from_interrupt_ge_a: assert property (core_in.return_from_interrupt |-> ##2 global_irq_enable)
		else $error("enable not set by return");
	ge_gate_a: assert property ($rose(vec_out.req) |-> global_irq_enable)
		else $error("vector with enable low");
	stack_gate_a: assert property ($rose(vec_out.req) |-> !$past(core_in.stack_full))
		else $error("vector with stack full");
	req_hold_a: assert property (vec_out.req && !core_in.ack |=> vec_out.req)
		else $error("request dropped unserviced");
	vec_code_a: assert property (vec_out.req |-> vec_out.vec inside {[3'h1:3'h5]})
		else $error("bad vector code");
	apb_ready_a: assert property (setup_s |=> pready ##1 !pready)
		else $error("ready not one cycle");
	apb_err_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
bind tbi_core tbi_core_asserts chk_u (.clk_sys, .reset, .psel, .penable, .pready,
	.pslverr, .core_in, .vec_out, .global_irq_enable);
`default_nettype wire

// ---- tb/tbi_core_tb_top.sv ----
// self-checking bench for the interrupt controller
`include "tbi_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tbi_core_tb_top;
	typedef struct packed {
		logic        rd;
		logic        err;
		logic [31:0] msk;
		logic [31:0] dat;
	} tbi_note_s;
	logic               clk_sys = 1'b0;
	logic               reset = 1'b1;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [11:0]        paddr = '0;
	logic [31:0]        pwdata = '0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               tick_osc = 1'b0;
	logic [3:0]         ev = '0;
	logic               stk = 1'b1;
	logic [31:0]        r;
	tbi_pkg::tbi_core_s core_in;
	tbi_pkg::tbi_vreq_s vec_out;
	logic               global_irq_enable;
	logic               wake_up;
	int                 err_count = 0;
	int                 check_count = 0;
	int                 wakes = 0;
	tbi_note_s          q[$];
	tbi_note_s          n;
	initial forever #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) tick_osc <= ~tick_osc;
	tbi_core dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tick_osc, .eeprom_write_done(ev[0]), .timer_p_match(ev[1]),
		.timer_a_match(ev[2]), .protection_comparator(ev[3]), .core_in, .vec_out,
		.global_irq_enable, .wake_up);
	tbi_cpu_model cpu_u (.clk_sys, .stack_full(stk), .vec_out, .core_in);
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test;
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_sys);
		q.push_back({!w, a > `TBI_ADDR_STATUS, m, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic kick(input logic [3:0] m);
		@(posedge clk_sys);
		ev <= ev ^ m;
		@(posedge clk_sys);
		ev[2:0] <= 3'h0;
		repeat (4) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		if (wake_up === 1'b1)
			wakes++;
		if (pready === 1'b1) begin
			n = q.pop_front();
			check("pslverr", pslverr, n.err);
			if (n.rd)
				check("prdata", prdata & n.msk, n.dat);
		end
	end
	initial begin
		repeat (25000) @(posedge clk_sys);
		err_count++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h8E59C62D));
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		apb(0, `TBI_ADDR_TBCTL, 0, 32'hFFFFFFFF, 32'h37);
		r = ($urandom | 32'h8) & ~32'h80;
		apb(1, `TBI_ADDR_TBCTL, r, 0, 0);
		apb(0, `TBI_ADDR_TBCTL, 0, 32'hFFFFFFFF, r & 32'hF7);
		apb(1, 12'h014, 0, 0, 0);
		apb(0, 12'h010, 0, 32'hFFFFFFFF, 0);
		kick(4'h1);
		check("wake_up", wakes, 1);
		kick(4'h1);
		check("wake_up", wakes, 1);
		kick(4'h6);
		kick(4'h8);
		apb(1, `TBI_ADDR_ENABLE, 32'hFE, 0, 0);
		repeat (10) @(posedge clk_sys);
		check("vec_req", vec_out.req, 0);
		apb(1, `TBI_ADDR_ENABLE, 32'hFF, 0, 0);
		repeat (10) @(posedge clk_sys);
		check("vec_req", vec_out.req, 0);
		apb(0, `TBI_ADDR_FLAGS, 0, 32'hFF, 32'h7C);
		stk <= 1'b0;
		repeat (60) @(posedge clk_sys);
		apb(0, `TBI_ADDR_FLAGS, 0, 32'hFF, 32'h18);
		apb(0, `TBI_ADDR_STATUS, 0, 32'h7, 32'h5);
		apb(0, `TBI_ADDR_ENABLE, 0, 32'hFF, 32'hFF);
		apb(1, `TBI_ADDR_ENABLE, 0, 0, 0);
		apb(1, `TBI_ADDR_FLAGS, 0, 0, 0);
		apb(1, `TBI_ADDR_TBCTL, 32'hC0, 0, 0);
		repeat (990) @(posedge clk_sys);
		apb(0, `TBI_ADDR_FLAGS, 0, 32'h3, 32'h0);
		repeat (60) @(posedge clk_sys);
		apb(0, `TBI_ADDR_FLAGS, 0, 32'h3, 32'h1);
		repeat (15200) @(posedge clk_sys);
		apb(0, `TBI_ADDR_FLAGS, 0, 32'h2, 32'h0);
		repeat (200) @(posedge clk_sys);
		apb(0, `TBI_ADDR_FLAGS, 0, 32'h2, 32'h2);
		finish_test;
	end
endmodule
`default_nettype wire

// ---- tb/tbi_cpu_model.sv ----
// core model that takes vectors and returns with return_from_interrupt
`timescale 1ns/1ps
`default_nettype none
module tbi_cpu_model (
	input  wire logic               clk_sys,
	input  wire logic               stack_full,
	input  wire tbi_pkg::tbi_vreq_s vec_out,
	output tbi_pkg::tbi_core_s      core_in
);
	initial begin
		core_in = '0;
		forever begin
			@(posedge clk_sys);
			core_in.stack_full <= stack_full;
			if (vec_out.req && !stack_full) begin
				repeat ($urandom_range(3)) @(posedge clk_sys);
				core_in.ack <= 1'b1;
				@(posedge clk_sys);
				core_in.ack <= 1'b0;
				repeat (4) @(posedge clk_sys);
				core_in.return_from_interrupt <= 1'b1;
				@(posedge clk_sys);
				core_in.return_from_interrupt <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verilog/tbi_core.sv ----
// timebase and event interrupt controller with apb registers
`include "tbi_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tbi_core (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             tick_osc,
	input  wire logic             eeprom_write_done,
	input  wire logic             timer_p_match,
	input  wire logic             timer_a_match,
	input  wire logic             protection_comparator,
	input  wire tbi_pkg::tbi_core_s core_in,
	output tbi_pkg::tbi_vreq_s    vec_out,
	output logic                  global_irq_enable,
	output logic                  wake_up
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0]  tbctl_r;
	logic [7:0]  enable_r;
	logic [6:0]  flags_r;
	logic [6:0]  flags_nxt;
	logic [1:0]  osc_sync_r;
	logic [1:0]  cmp_sync_r;
	logic        osc_prev_r;
	logic        cmp_prev_r;
	logic [1:0]  sysdiv_r;
	logic [15:0] div_r;
	logic [15:0] div_prev_r;
	logic        tick_in;
	logic        tick0_ovf;
	logic        tick1_ovf;
	logic [3:0]  t0_bit;
	logic [3:0]  t1_bit;
	logic        wr_en;
	logic        rd_en;
	logic        map_hit;
	tbi_pkg::tbi_vec_e sel_vec;
	tbi_pkg::tbi_vec_e taken_vec;
	logic [6:0]  svc_clr;
	logic [6:0]  sw_clr;
	logic [6:0]  sw_set;
	logic [6:0]  hw_set;

	////////////////////////////////////////////////////////////////////////
	// synchronisers for asynchronous inputs
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			osc_sync_r <= 2'h0;
			cmp_sync_r <= 2'h0;
			osc_prev_r <= 1'b0;
			cmp_prev_r <= 1'b0;
		end else begin
			osc_sync_r <= {osc_sync_r[0], tick_osc};
			cmp_sync_r <= {cmp_sync_r[0], protection_comparator};
			osc_prev_r <= osc_sync_r[1];
			cmp_prev_r <= cmp_sync_r[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tick input clock and divider chain
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sysdiv_r <= 2'h0;
		end else begin
			sysdiv_r <= sysdiv_r + 2'h1;
		end
	end

	always_comb begin
		if (tbctl_r[`TBI_BIT_CKSEL]) begin
			tick_in = (sysdiv_r == `TBI_SYSDIV);
		end else begin
			tick_in = osc_sync_r[1] & ~osc_prev_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || !tbctl_r[`TBI_BIT_ON]) begin
			div_r      <= 16'h0000;
			div_prev_r <= 16'h0000;
		end else begin
			div_prev_r <= div_r;
			if (tick_in) begin
				div_r <= div_r + 16'h0001;
			end
		end
	end

	// falling edge of bit n-1 marks each 2^n input clocks
	assign t0_bit    = 4'(`TBI_T0_BASE - 1) + {1'b0, tbctl_r[2:0]};
	assign t1_bit    = 4'(`TBI_T1_BASE - 1) + {2'h0, tbctl_r[5:4]};
	assign tick0_ovf = div_prev_r[t0_bit] & ~div_r[t0_bit];
	assign tick1_ovf = div_prev_r[t1_bit] & ~div_r[t1_bit];

	////////////////////////////////////////////////////////////////////////
	// priority select and vectoring
	always_comb begin
		sel_vec = tbi_pkg::TBI_V_NONE;
		if (enable_r[`TBI_EN_GLOBAL] && !core_in.stack_full) begin
			if (flags_r[`TBI_FL_CMP] && enable_r[`TBI_EN_CMP]) begin
				sel_vec = tbi_pkg::TBI_V_CMP;
			end else if (flags_r[`TBI_FL_TICK0] && enable_r[`TBI_EN_TICK0]) begin
				sel_vec = tbi_pkg::TBI_V_TICK0;
			end else if (flags_r[`TBI_FL_TICK1] && enable_r[`TBI_EN_TICK1]) begin
				sel_vec = tbi_pkg::TBI_V_TICK1;
			end else if (flags_r[`TBI_FL_EEPROM] && enable_r[`TBI_EN_EEPROM]) begin
				sel_vec = tbi_pkg::TBI_V_EEPROM;
			end else if (flags_r[`TBI_FL_SHARED] && enable_r[`TBI_EN_SHARED]
				&& ((flags_r[`TBI_FL_TMP] && enable_r[`TBI_EN_TMP])
				|| (flags_r[`TBI_FL_TMA] && enable_r[`TBI_EN_TMA]))) begin
				sel_vec = tbi_pkg::TBI_V_SHARED;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			vec_out   <= '0;
			taken_vec <= tbi_pkg::TBI_V_NONE;
		end else begin
			if (core_in.ack) begin
				vec_out   <= '0;
			end else begin
				vec_out.req <= (sel_vec != tbi_pkg::TBI_V_NONE);
				vec_out.vec <= sel_vec;
			end
			if (core_in.ack && vec_out.req) begin
				taken_vec <= tbi_pkg::tbi_vec_e'(vec_out.vec);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request flags
	always_comb begin
		svc_clr = 7'h00;
		if (core_in.ack && vec_out.req) begin
			case (tbi_pkg::tbi_vec_e'(vec_out.vec))
				tbi_pkg::TBI_V_CMP:    svc_clr[`TBI_FL_CMP]    = 1'b1;
				tbi_pkg::TBI_V_TICK0:  svc_clr[`TBI_FL_TICK0]  = 1'b1;
				tbi_pkg::TBI_V_TICK1:  svc_clr[`TBI_FL_TICK1]  = 1'b1;
				tbi_pkg::TBI_V_EEPROM: svc_clr[`TBI_FL_EEPROM] = 1'b1;
				tbi_pkg::TBI_V_SHARED: svc_clr[`TBI_FL_SHARED] = 1'b1;
				default:               svc_clr = 7'h00;
			endcase
		end
	end

	assign hw_set[`TBI_FL_TICK0]  = tick0_ovf;
	assign hw_set[`TBI_FL_TICK1]  = tick1_ovf;
	assign hw_set[`TBI_FL_EEPROM] = eeprom_write_done;
	assign hw_set[`TBI_FL_TMP]    = timer_p_match;
	assign hw_set[`TBI_FL_TMA]    = timer_a_match;
	assign hw_set[`TBI_FL_SHARED] = timer_p_match | timer_a_match;
	assign hw_set[`TBI_FL_CMP]    = cmp_sync_r[1] ^ cmp_prev_r;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign map_hit = (paddr == `TBI_ADDR_TBCTL) || (paddr == `TBI_ADDR_ENABLE)
		|| (paddr == `TBI_ADDR_FLAGS) || (paddr == `TBI_ADDR_STATUS);
	// flag register: write 1 sets, write 0 clears (lets software pre-set)
	assign sw_set = (wr_en && paddr == `TBI_ADDR_FLAGS) ? pwdata[6:0] : 7'h00;
	assign sw_clr = (wr_en && paddr == `TBI_ADDR_FLAGS) ? ~pwdata[6:0] : 7'h00;
	// hardware set wins over any clear
	assign flags_nxt = hw_set | sw_set | (flags_r & ~sw_clr & ~svc_clr);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flags_r <= 7'h00;
			wake_up <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			wake_up <= |(flags_nxt & ~flags_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers and apb slave
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tbctl_r <= `TBI_TBCTL_RST;
		end else if (wr_en && paddr == `TBI_ADDR_TBCTL) begin
			tbctl_r <= pwdata[7:0] & `TBI_TBCTL_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			enable_r <= 8'h00;
		end else begin
			if (wr_en && paddr == `TBI_ADDR_ENABLE) begin
				enable_r <= pwdata[7:0];
			end
			if (core_in.ack && vec_out.req) begin
				enable_r[`TBI_EN_GLOBAL] <= 1'b0;
			end else if (core_in.return_from_interrupt) begin
				enable_r[`TBI_EN_GLOBAL] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			global_irq_enable <= 1'b0;
		end else begin
			global_irq_enable <= enable_r[`TBI_EN_GLOBAL];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~map_hit;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`TBI_ADDR_TBCTL:  prdata <= {24'h00_0000, tbctl_r};
					`TBI_ADDR_ENABLE: prdata <= {24'h00_0000, enable_r};
					`TBI_ADDR_FLAGS:  prdata <= {25'h000_0000, flags_r};
					`TBI_ADDR_STATUS: prdata <= {29'h0000_0000, taken_vec};
					default:          prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- verilog/tbi_params.svh ----
// constants for the timebase and event interrupt block
`ifndef TBI_PARAMS_SVH
`define TBI_PARAMS_SVH
`define TBI_ADDR_TBCTL     12'h000
`define TBI_ADDR_ENABLE    12'h004
`define TBI_ADDR_FLAGS     12'h008
`define TBI_ADDR_STATUS    12'h00C
`define TBI_TBCTL_RST      8'h37
`define TBI_TBCTL_MASK     8'hF7
`define TBI_BIT_ON         7
`define TBI_BIT_CKSEL      6
`define TBI_EN_GLOBAL      0
`define TBI_EN_TICK0       1
`define TBI_EN_TICK1       2
`define TBI_EN_EEPROM      3
`define TBI_EN_TMP         4
`define TBI_EN_TMA         5
`define TBI_EN_SHARED      6
`define TBI_EN_CMP         7
`define TBI_FL_TICK0       0
`define TBI_FL_TICK1       1
`define TBI_FL_EEPROM      2
`define TBI_FL_TMP         3
`define TBI_FL_TMA         4
`define TBI_FL_SHARED      5
`define TBI_FL_CMP         6
`define TBI_SYSDIV         2'h3
`define TBI_T0_BASE        8
`define TBI_T1_BASE        12
`endif

// ---- verilog/tbi_pkg.sv ----
// types for the timebase and event interrupt block
package tbi_pkg;
	typedef enum logic [2:0] {
		TBI_V_NONE,
		TBI_V_CMP,
		TBI_V_TICK0,
		TBI_V_TICK1,
		TBI_V_EEPROM,
		TBI_V_SHARED
	} tbi_vec_e;
	typedef struct packed {
		logic       req;
		logic [2:0] vec;
	} tbi_vreq_s;
	typedef struct packed {
		logic ack;
		logic return_from_interrupt;
		logic ret;
		logic stack_full;
	} tbi_core_s;
endpackage
